// *** seq_defs.svh ***
// Offsets, bit positions, reset values, the unmaskable status mask and the one-frame count
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH
`define OFS_CONTROL 6'h00
`define OFS_CHAN_STATUS 6'h04
`define OFS_CTRL_STATUS 6'h08
`define OFS_FRAME_COUNT 6'h0C
`define OFS_REFRESH 6'h10
`define OFS_IRQ_MASK 6'h14
`define BIT_HALT_AFTER_FRAME 7
`define BIT_GO 6
`define BIT_HALT 5
`define BIT_TRIGGER_EN 3
`define BIT_SEQ_DONE 7
`define BIT_FRAME_DONE 6
`define BIT_CHAN_ACTIVE 3
`define BIT_CTRL_IRQ 0
`define UNMASKABLE 8'h0E
`define RST_FRAME_COUNT 8'h01
`define RST_REFRESH 16'h0000
`define RST_IRQ_MASK 8'h00
`define ONE_FRAME 8'h01
`endif

// *** seq_pkg.sv ***
// Types shared by the sequence control block
package seq_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ONE_SHOT,
        ST_LOOP_RUN,
        ST_LOOP_WAIT,
        ST_STOPPING
    } chan_state_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [5:0] address;
        logic [31:0] writedata;
    } avmm_req_t;

    typedef struct packed {
        logic [15:0] left;
        logic [7:0] frames;
    } timer_state_t;

    typedef struct packed {
        chan_state_t state;
        logic go;
        logic te;
        logic halt_pend;
        logic both_flags;
        logic [7:0] flc;
        logic [15:0] interval;
        logic [7:0] mask;
        logic [7:0] chst;
        logic ctrl_irq;
        logic ack;
        logic [31:0] rdata;
        logic seq_start;
        logic halt_xfer;
        logic irq_n;
    } ctrl_state_t;
endpackage

// *** loop_timer.sv ***
// Refresh interval timer and frame loop counter
`timescale 1ns/1ps
`include "seq_defs.svh"
module loop_timer
    import seq_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic restart,
    input wire logic arm,
    input wire logic frame_end,
    input wire logic [15:0] interval,
    input wire logic [7:0] frame_loop_count,
    output logic interval_tick,
    output logic last_frame
);
    timer_state_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        if (arm) begin
            s_d.left = interval;
        end else if (s_q.left != 16'h0000) begin
            s_d.left = s_q.left - 16'h0001;
        end
        if (restart) begin
            s_d.frames = 8'h00;
        end else if (frame_end) begin
            s_d.frames = s_q.frames + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign interval_tick = (s_q.left == 16'h0001) && !arm;
    // A count of zero loops forever
    assign last_frame = (frame_loop_count != 8'h00) &&
                        (s_q.frames + 8'h01 == frame_loop_count);
endmodule // loop_timer

// *** seq_ctrl.sv ***
// Sequence start and stop control with channel status and interrupt
`timescale 1ns/1ps
`include "seq_defs.svh"
// What this block does
// - Idle go write starts one sequence
// - One-shot active ignores go writes
// - Halt in read: NACK then STOP
// - Halt in write: STOP after ACK
// - One-shot halt sets only sequence-done
// - Some loop states stop immediately on halt
// - Halt-after-frame in refresh loop transfer stops at frame end
// - Loop halt in transfer sets both flags
// - Count and trigger enable select mode
// - Go zero during loop idle ignored
// - Status bit 3 shows channel active
// - Channel status eight bits, read-only
// - Bus error bits cannot be masked
// - Any unmasked status drives irq low
// - Reading channel status clears request
// - Controller status read clears controller irq
// - After clear only new events set
// - Halt writes ignored while go zero
// - Halt beats halt-after-frame
// - Bit 7 is sequence-done
// - Bit 6 is frame-loop-done
module seq_ctrl
    import seq_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic frame_stop,
    input wire logic trigger_tick,
    input wire logic [5:0] err_set,
    input wire logic ctrl_event,
    output logic seq_start,
    output logic halt_xfer,
    output logic chan_active,
    output logic irq_n
);
    ctrl_state_t s_q, s_d;
    avmm_req_t req;
    logic wr_ok, rd_ok, tick, last_frame, arm, restart;
    logic halt_w, haf_w, go_w;
    logic [7:0] st_set;

    function automatic logic [7:0] irq_sources(input logic [7:0] st,
                                               input logic [7:0] mask);
        irq_sources = st & (~mask | `UNMASKABLE);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Bus slave with one wait state

    assign req = '{read: read, write: write, address: address,
                   writedata: writedata};
    assign waitrequest = (req.read || req.write) && !s_q.ack;
    assign wr_ok = req.write && s_q.ack;
    assign rd_ok = req.read && s_q.ack;
    assign halt_w = wr_ok && (req.address == `OFS_CONTROL) &&
                    req.writedata[`BIT_HALT];
    assign haf_w = wr_ok && (req.address == `OFS_CONTROL) &&
                   req.writedata[`BIT_HALT_AFTER_FRAME];
    assign go_w = wr_ok && (req.address == `OFS_CONTROL) &&
                  req.writedata[`BIT_GO];

    loop_timer u_timer (
        .clk(clk),
        .srst(srst),
        .restart(restart),
        .arm(arm),
        .frame_end(frame_stop),
        .interval(s_q.interval),
        .frame_loop_count(s_q.flc),
        .interval_tick(tick),
        .last_frame(last_frame)
    );

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_d = s_q;
        st_set = {2'b00, err_set};
        arm = 1'b0;
        restart = 1'b0;
        s_d.seq_start = 1'b0;
        s_d.ack = (req.read || req.write) && !s_q.ack;
        // Read data captured in the wait cycle, stands when accepted
        if (req.read && !s_q.ack) begin
            case (req.address)
                `OFS_CONTROL: s_d.rdata = {24'h000000,
                    s_q.halt_pend, s_q.go, s_q.halt_xfer, 1'b0,
                    s_q.te, 3'b000};
                `OFS_CHAN_STATUS: s_d.rdata = {24'h000000, s_q.chst};
                `OFS_CTRL_STATUS: s_d.rdata = {28'h0000000,
                    s_q.state != ST_IDLE, 2'b00, s_q.ctrl_irq};
                `OFS_FRAME_COUNT: s_d.rdata = {24'h000000, s_q.flc};
                `OFS_REFRESH: s_d.rdata = {16'h0000, s_q.interval};
                `OFS_IRQ_MASK: s_d.rdata = {24'h000000, s_q.mask};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
        if (wr_ok && s_q.state == ST_IDLE) begin
            case (req.address)
                `OFS_CONTROL: s_d.te = req.writedata[`BIT_TRIGGER_EN];
                `OFS_FRAME_COUNT: s_d.flc = req.writedata[7:0];
                `OFS_REFRESH: s_d.interval = req.writedata[15:0];
                default: ;
            endcase
        end
        if (wr_ok && req.address == `OFS_IRQ_MASK) begin
            s_d.mask = req.writedata[7:0];
        end
        case (s_q.state)
            ST_IDLE: begin
                if (go_w) begin
                    s_d.go = 1'b1;
                    s_d.seq_start = !req.writedata[`BIT_TRIGGER_EN];
                    s_d.te = req.writedata[`BIT_TRIGGER_EN];
                    restart = 1'b1;
                    s_d.both_flags = req.writedata[`BIT_TRIGGER_EN] ||
                                     (s_q.flc != `ONE_FRAME);
                    s_d.state = req.writedata[`BIT_TRIGGER_EN] ?
                        ST_LOOP_WAIT : (s_q.flc == `ONE_FRAME) ?
                        ST_ONE_SHOT : ST_LOOP_RUN;
                end
            end
            ST_ONE_SHOT: begin
                if (frame_stop) begin
                    st_set[`BIT_SEQ_DONE] = 1'b1;
                    s_d.state = ST_IDLE;
                end else if (halt_w) begin
                    s_d.halt_xfer = 1'b1;
                    s_d.state = ST_STOPPING;
                end
            end
            ST_LOOP_RUN: begin
                if (frame_stop) begin
                    if (last_frame || s_q.halt_pend) begin
                        st_set[7:6] = 2'b11;
                        s_d.state = ST_IDLE;
                    end else begin
                        arm = 1'b1;
                        s_d.state = ST_LOOP_WAIT;
                    end
                end else if (s_q.te && (halt_w || haf_w)) begin
                    st_set[7:6] = 2'b11;
                    s_d.state = ST_IDLE;
                end else if (halt_w) begin
                    s_d.halt_xfer = 1'b1;
                    s_d.state = ST_STOPPING;
                end else if (haf_w) begin
                    s_d.halt_pend = 1'b1;
                end
            end
            ST_LOOP_WAIT: begin
                if (!s_q.te && (halt_w || haf_w)) begin
                    st_set[7:6] = 2'b11;
                    s_d.state = ST_IDLE;
                end else if (s_q.te && halt_w) begin
                    s_d.halt_xfer = 1'b1;
                    s_d.state = ST_STOPPING;
                end else if (s_q.te && haf_w) begin
                    s_d.halt_xfer = 1'b1;
                    s_d.state = ST_STOPPING;
                end else if (s_q.te ? trigger_tick : tick) begin
                    s_d.seq_start = 1'b1;
                    s_d.state = ST_LOOP_RUN;
                end
            end
            ST_STOPPING: begin
                if (frame_stop) begin
                    st_set[`BIT_SEQ_DONE] = 1'b1;
                    st_set[`BIT_FRAME_DONE] = s_q.both_flags;
                    s_d.state = ST_IDLE;
                end
            end
            default: s_d.state = ST_IDLE;
        endcase
        if (s_d.state == ST_IDLE) begin
            s_d.go = 1'b0;
            s_d.halt_pend = 1'b0;
            s_d.halt_xfer = 1'b0;
        end
        s_d.chst = ((rd_ok && req.address == `OFS_CHAN_STATUS) ?
                    (s_q.chst & ~s_q.rdata[7:0]) : s_q.chst) | st_set;
        s_d.ctrl_irq = ((rd_ok && req.address == `OFS_CTRL_STATUS) ?
                        (s_q.ctrl_irq && !s_q.rdata[0]) : s_q.ctrl_irq)
                       | ctrl_event;
        s_d.irq_n = !((|irq_sources(s_d.chst, s_d.mask)) || s_d.ctrl_irq);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.state <= ST_IDLE;
            s_q.flc <= `RST_FRAME_COUNT;
            s_q.interval <= `RST_REFRESH;
            s_q.mask <= `RST_IRQ_MASK;
            s_q.irq_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign readdata = s_q.rdata;
    assign seq_start = s_q.seq_start;
    assign halt_xfer = s_q.halt_xfer;
    assign chan_active = s_q.state != ST_IDLE;
    assign irq_n = s_q.irq_n;

    ////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_idle_go;
        s_q.state == ST_IDLE && go_w && !req.writedata[`BIT_TRIGGER_EN]
            && s_q.flc == `ONE_FRAME;
    endsequence
    sequence s_shot_halt;
        s_q.state == ST_ONE_SHOT && halt_w && !frame_stop;
    endsequence

    property p_go_start;
        @(posedge clk) disable iff (srst)
        s_idle_go |=> seq_start && s_q.state == ST_ONE_SHOT;
    endproperty
    a_go_start: assert property (p_go_start)
        else $error("go write did not start sequence");

    property p_go_ignored;
        @(posedge clk) disable iff (srst)
        s_q.state == ST_ONE_SHOT && wr_ok && !halt_w && !frame_stop
            |=> s_q.state == ST_ONE_SHOT && !seq_start;
    endproperty
    a_go_ignored: assert property (p_go_ignored)
        else $error("active one-shot reacted to write");

    property p_halt_read;
        @(posedge clk) disable iff (srst)
        s_shot_halt |=> halt_xfer ##0 s_q.state == ST_STOPPING;
    endproperty
    a_halt_read: assert property (p_halt_read)
        else $error("halt not passed to engine");

    property p_halt_hold;
        @(posedge clk) disable iff (srst)
        halt_xfer && !frame_stop |=> halt_xfer;
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("halt dropped before stop");

    property p_sd_only;
        @(posedge clk) disable iff (srst)
        s_q.state == ST_STOPPING && !s_q.both_flags && frame_stop
            && !rd_ok |=> s_q.chst[7] && s_q.chst[6] == $past(s_q.chst[6]);
    endproperty
    a_sd_only: assert property (p_sd_only)
        else $error("one-shot halt set wrong flags");

    property p_immediate;
        @(posedge clk) disable iff (srst)
        s_q.state == ST_LOOP_WAIT && !s_q.te && (halt_w || haf_w)
            |=> s_q.state == ST_IDLE && s_q.chst[7:6] == 2'b11;
    endproperty
    a_immediate: assert property (p_immediate)
        else $error("refresh idle halt not immediate");

    property p_status_irq;
        @(posedge clk) disable iff (srst)
        (|(s_q.chst & `UNMASKABLE)) |-> !irq_n;
    endproperty
    a_status_irq: assert property (p_status_irq)
        else $error("unmaskable status did not assert irq");

    property p_read_clear;
        @(posedge clk) disable iff (srst)
        rd_ok && req.address == `OFS_CHAN_STATUS && err_set == 6'h00
            && s_q.chst == readdata[7:0]
            && s_q.state == ST_IDLE && !go_w |=> s_q.chst == 8'h00;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("channel status read did not clear");

    property p_halt_idle;
        @(posedge clk) disable iff (srst)
        s_q.state == ST_IDLE && (halt_w || haf_w) && !go_w
            |=> s_q.state == ST_IDLE && !halt_xfer;
    endproperty
    a_halt_idle: assert property (p_halt_idle)
        else $error("halt acted while go clear");

    property p_back_idle;
        @(posedge clk) disable iff (srst)
        s_q.state == ST_STOPPING && frame_stop
            |=> !chan_active ##1 !chan_active || seq_start || go_w;
    endproperty
    a_back_idle: assert property (p_back_idle)
        else $error("channel not idle after stop");
endmodule // seq_ctrl

// *** engine_model.sv ***
// Behavioural serial engine answering start and halt with frame stops
`timescale 1ns/1ps
module engine_model #(
    parameter int FRAME_LEN = 40,
    parameter int HALT_LEN = 3
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic seq_start,
    input wire logic halt_xfer,
    output logic frame_stop
);
    int cnt_q;
    logic busy_q;
    always_ff @(posedge clk) begin
        frame_stop <= 1'b0;
        if (srst) begin
            busy_q <= 1'b0;
            cnt_q <= 0;
        end else if (seq_start) begin
            busy_q <= 1'b1;
            cnt_q <= FRAME_LEN;
        end else if (halt_xfer && !frame_stop
                     && (!busy_q || cnt_q > HALT_LEN)) begin
            busy_q <= 1'b1;
            cnt_q <= HALT_LEN;
        end else if (busy_q && cnt_q == 1) begin
            busy_q <= 1'b0;
            frame_stop <= 1'b1;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 1;
        end
    end
endmodule // engine_model

// *** seq_ctrl_tb.sv ***
// Self-checking bench for the sequence start and stop control
`timescale 1ns/1ps
`include "seq_defs.svh"
module seq_ctrl_tb;
    logic clk, srst, read, write, frame_stop, trigger_tick, ctrl_event;
    logic [5:0] address, err_set, err;
    logic [31:0] writedata, readdata, q;
    logic waitrequest, seq_start, halt_xfer, chan_active, irq_n, ok;
    logic [7:0] msk;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;

    seq_ctrl u_dut (.clk(clk), .srst(srst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .frame_stop(frame_stop),
        .trigger_tick(trigger_tick), .err_set(err_set),
        .ctrl_event(ctrl_event), .seq_start(seq_start),
        .halt_xfer(halt_xfer), .chan_active(chan_active), .irq_n(irq_n));
    engine_model u_eng (.clk(clk), .srst(srst), .seq_start(seq_start),
        .halt_xfer(halt_xfer), .frame_stop(frame_stop));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic rd_n, input logic [5:0] a,
        input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= ~rd_n;
        write <= rd_n;
        @(posedge clk);
        while (waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [5:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic pulse(input logic [5:0] e, input logic c, input logic t);
        @(posedge clk);
        err_set <= e;
        ctrl_event <= c;
        trigger_tick <= t;
        @(posedge clk);
        err_set <= 6'h00;
        ctrl_event <= 1'b0;
        trigger_tick <= 1'b0;
    endtask
    task automatic wait_for(input int which, input logic lvl);
        logic s;
        ok = 1'b0;
        for (int i = 0; i < 300 && !ok; i++) begin
            @(negedge clk);
            case (which)
                0: s = seq_start;
                1: s = chan_active;
                2: s = halt_xfer;
                default: s = frame_stop;
            endcase
            ok = (s === lvl);
        end
    endtask
    function automatic logic [31:0] st(logic sd, logic frame_loop_done_flag);
        return {24'h0, sd, frame_loop_done_flag, 6'h00};
    endfunction
    task automatic finish_seq(input logic [31:0] exp);
        wait_for(1, 1'b0);
        check("back to idle", ok, 1'b1);
        repeat (2) @(negedge clk);
        check("irq asserted", irq_n, 1'b0);
        rd(`OFS_CHAN_STATUS);
        check("channel status", q, exp);
        repeat (2) @(negedge clk);
        check("irq cleared", irq_n, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 6'h00;
        writedata = 32'h0;
        trigger_tick = 1'b0;
        err_set = 6'h00;
        ctrl_event = 1'b0;
        void'($urandom(32'h6690E0CE));
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rd(`OFS_FRAME_COUNT);
        check("frame count reset", q, 32'h1);
        rd(6'h3C);
        check("unmapped read", q, 32'h0);
        wr(`OFS_CONTROL, 32'h0);
        wait_for(0, 1'b1);
        check("go zero", ok, 1'b0);
        wr(`OFS_CONTROL, 32'h40);
        wait_for(0, 1'b1);
        check("go start", ok, 1'b1);
        rd(`OFS_CTRL_STATUS);
        check("active bit", q[3], 1'b1);
        wr(`OFS_CONTROL, 32'h40);
        @(negedge clk);
        check("go ignored", {seq_start, halt_xfer, chan_active}, 3'b001);
        finish_seq(st(1'b1, 1'b0));
        rd(`OFS_CHAN_STATUS);
        check("status cleared", q, 32'h0);
        wr(`OFS_CONTROL, 32'h40);
        wait_for(0, 1'b1);
        wr(`OFS_CONTROL, 32'hE0);
        wait_for(2, 1'b1);
        check("halt priority", ok, 1'b1);
        finish_seq(st(1'b1, 1'b0));
        wr(`OFS_CONTROL, 32'hA0);
        wait_for(2, 1'b1);
        check("halt with go zero", ok, 1'b0);
        $display("test one shot done");
        wr(`OFS_FRAME_COUNT, 32'h3);
        wr(`OFS_REFRESH, 32'd60);
        wr(`OFS_CONTROL, 32'h40);
        for (int i = 0; i < 3; i++) begin
            wait_for(0, 1'b1);
            check("loop frame", ok, 1'b1);
            if (i == 1) begin
                wait_for(3, 1'b1);
                wr(`OFS_CONTROL, 32'h0);
                @(negedge clk);
                check("go zero loop idle", chan_active, 1'b1);
            end
        end
        finish_seq(st(1'b1, 1'b1));
        wr(`OFS_FRAME_COUNT, 32'h0);
        for (int k = 0; k < 3; k++) begin
            wr(`OFS_CONTROL, 32'h40);
            wait_for(0, 1'b1);
            if (k == 1) begin
                wait_for(3, 1'b1);
            end
            wr(`OFS_CONTROL, (k == 0) ? 32'hC0 : 32'h60);
            if (k == 0) begin
                check("frame end", {halt_xfer, chan_active}, 2'b01);
            end
            if (k == 1) begin
                repeat (2) @(negedge clk);
                check("loop idle drop", chan_active, 1'b0);
            end
            if (k == 2) begin
                wait_for(2, 1'b1);
                check("loop halt", ok, 1'b1);
            end
            finish_seq(st(1'b1, 1'b1));
        end
        $display("test refresh loop done");
        wr(`OFS_CONTROL, 32'h48);
        pulse(6'h00, 1'b0, 1'b1);
        wait_for(0, 1'b1);
        check("trigger frame", ok, 1'b1);
        wr(`OFS_CONTROL, 32'h68);
        finish_seq(st(1'b1, 1'b1));
        wr(`OFS_CONTROL, 32'h48);
        wr(`OFS_CONTROL, 32'hC8);
        finish_seq(st(1'b1, 1'b1));
        wr(`OFS_CONTROL, 32'h0);
        $display("test trigger loop done");
        pulse(6'h00, 1'b1, 1'b0);
        repeat (2) @(negedge clk);
        check("ctrl irq", irq_n, 1'b0);
        rd(`OFS_CHAN_STATUS);
        repeat (2) @(negedge clk);
        check("ctrl irq kept", irq_n, 1'b0);
        rd(`OFS_CTRL_STATUS);
        check("ctrl irq bit", q[0], 1'b1);
        repeat (2) @(negedge clk);
        check("ctrl irq cleared", irq_n, 1'b1);
        $display("test controller irq done");
        for (int i = 0; i < 8; i++) begin
            msk = 8'($urandom);
            err = 6'($urandom);
            if (i == 0) begin
                msk = 8'hFF;
                err = 6'h0E;
            end
            wr(`OFS_IRQ_MASK, {24'h0, msk});
            pulse(err, 1'b0, 1'b0);
            repeat (2) @(negedge clk);
            check("err irq", irq_n,
                ~|({2'b00, err} & (~msk | `UNMASKABLE)));
            wr(`OFS_CHAN_STATUS, 32'hFF);
            rd(`OFS_CHAN_STATUS);
            check("err status", q, {26'h0, err});
            repeat (2) @(negedge clk);
            check("err irq cleared", irq_n, 1'b1);
        end
        $display("test error status done");
        final_report();
    end
endmodule // seq_ctrl_tb
